// ### design/sbsd_defs.vh
// Purpose: constants for the system bus space decoder
// Assumes: 34-bit system address, PCI byte enables active low
// Notes: space codes are one-hot, one bit per decoded space
`ifndef SBSD_DEFS_VH
`define SBSD_DEFS_VH

// quadrant codes on address bits 33:32
`define SBSD_QUAD_CACHE 2'h0
`define SBSD_QUAD_LOCAL 2'h1
`define SBSD_QUAD_SPARSE 2'h2
`define SBSD_QUAD_DENSE 2'h3

// one-hot space select bit positions
`define SBSD_SP_CACHE 0
`define SBSD_SP_NONCACHE 1
`define SBSD_SP_MC_CSR 2
`define SBSD_SP_BR_CSR 3
`define SBSD_SP_IACK_SPC 4
`define SBSD_SP_SPARSE_IO 5
`define SBSD_SP_CONFIG 6
`define SBSD_SP_SPARSE_MEM 7
`define SBSD_SP_DENSE_MEM 8
`define SBSD_SP_W 9

// pci command codes
`define SBSD_CMD_IACK 4'h0
`define SBSD_CMD_SPECIAL 4'h1
`define SBSD_CMD_IO_RD 4'h2
`define SBSD_CMD_IO_WR 4'h3
`define SBSD_CMD_MEM_RD 4'h6
`define SBSD_CMD_MEM_WR 4'h7
`define SBSD_CMD_CFG_RD 4'ha
`define SBSD_CMD_CFG_WR 4'hb
`define SBSD_CMD_NONE 4'hf

// byte-enable values (active low)
`define SBSD_BE_NONE 4'hf
`define SBSD_BE_ALL 4'h0

// io space reserved low region: 256 KB = address bits 17:0
`define SBSD_IO_RSV_TOP 17

// decoder pipeline state codes
`define SBSD_ST_IDLE 2'h1
`define SBSD_ST_HOLD 2'h2

`endif

// ### design/sbsd_sparse_be.v
// Purpose: sparse byte-enable encoder from system address bits 6:3
// Assumes: input taken as the low length/mask field of a sparse access
// Notes: illegal codes give no lanes and raise the illegal flag
`timescale 1ns/1ps
`default_nettype none
`include "sbsd_defs.vh"

module sbsd_sparse_be (
   // length and lane field
   input wire [3:0] len_lane,
   // encoded outputs
   output reg [3:0] byte_en_n,
   output reg [2:0] low_ad,
   output reg quad_len,
   output reg illegal
);

   // ********************************
   // lane decode
   // ********************************
   // map lane in 6:5 and length in 4:3 to active-low enables
   always @* begin
      byte_en_n = `SBSD_BE_NONE;
      low_ad = {1'b0, len_lane[3:2]};
      quad_len = 1'b0;
      illegal = 1'b0;
      case (len_lane)
         4'h0: byte_en_n = 4'he;
         4'h4: byte_en_n = 4'hd;
         4'h8: byte_en_n = 4'hb;
         4'hc: byte_en_n = 4'h7;
         4'h1: byte_en_n = 4'hc;
         4'h5: byte_en_n = 4'h9;
         4'h9: byte_en_n = 4'h3;
         4'h2: byte_en_n = 4'h8;
         4'h6: byte_en_n = 4'h1;
         4'h3: byte_en_n = `SBSD_BE_ALL;
         4'hf: begin
            byte_en_n = `SBSD_BE_ALL;
            low_ad = 3'h0;
            quad_len = 1'b1;
         end
         default: begin
            illegal = 1'b1;
            low_ad = 3'h0;
         end
      endcase
   end

endmodule // sbsd_sparse_be
`default_nettype wire

// ### design/sbsd_space_decoder.v
// Purpose: decode the 34-bit system address into target spaces and pci commands
// Assumes: request qualifiers are synchronous and held for one cycle per access
// Notes: space select is combinational; the pci command group is registered
`timescale 1ns/1ps
`default_nettype none
`include "sbsd_defs.vh"

// Overview of operation
// - quadrant 00 is cacheable memory and the memory controller claims every access there.
// - quadrant 01 with bits 31:28 of 0xxx is noncacheable memory and skips the level-two cache.
// - quadrant 01 with 100x selects memory-controller registers, claimed always, data stream only.
// - quadrant 01 with 1010 selects bridge registers and the bridge claims every access there.
// - quadrant 01 with 1011 is claimed by the bridge; a read is interrupt acknowledge, a write special.
// - interrupt acknowledge takes byte enables from bits 6:3 by the sparse code and ignores bits 26:7.
// - a special-cycle write may carry any address and byte enables.
// - quadrant 01 with 110x is 16 MB of io space, data only, its low 256 KB kept for legacy devices.
// - quadrant 01 with 111x is configuration space, issued as configuration reads or writes.
// - quadrant 10 is sparse memory of 128 MB whose low bits carry byte masks and length.
// - sparse memory moves at most a quadword, fetches nothing extra and never prefetches.
// - quadrant 11 is 4 GB of dense memory, data only, where prefetch is allowed.
// - only cacheable and noncacheable memory accept instruction fetch and dma accesses.
// - generated pci byte enables are active low, zero marking a valid lane.
module sbsd_space_decoder (
   // clock and reset
   input wire clock,
   input wire srst,
   // processor side bus request
   input wire [33:0] system_address,
   input wire req_valid,
   input wire req_write,
   input wire req_istream,
   input wire req_dma,
   input wire longword_store_instruction,
   // combinational decode
   output wire [`SBSD_SP_W-1:0] space_sel,
   output wire mc_claim,
   output wire br_claim,
   output wire l2_bypass,
   output wire access_ok,
   // registered pci transaction
   output reg pci_valid_ff,
   output reg [3:0] pci_cmd_ff,
   output reg [31:0] pci_addr_ff,
   output reg [3:0] pci_be_n_ff,
   output reg pci_prefetch_ok_ff,
   output reg pci_quad_len_ff,
   output reg pci_io_legacy_ff,
   output reg pci_illegal_ff
);

   // ********************************
   // space decode
   // ********************************
   // quadrant and sub-space fields of the address
   wire [1:0] quad;
   wire [3:0] sub;
   reg [`SBSD_SP_W-1:0] sel;
   assign quad = system_address[33:32];
   assign sub = system_address[31:28];

   // one-hot select from bits 33:28 only
   always @* begin
      sel = {`SBSD_SP_W{1'b0}};
      case (quad)
         `SBSD_QUAD_CACHE: sel[`SBSD_SP_CACHE] = 1'b1;
         `SBSD_QUAD_SPARSE: sel[`SBSD_SP_SPARSE_MEM] = 1'b1;
         `SBSD_QUAD_DENSE: sel[`SBSD_SP_DENSE_MEM] = 1'b1;
         default: begin
            // quadrant 01 splits on bits 31:28; the else chain keeps one bit set
            if (!sub[3])
               sel[`SBSD_SP_NONCACHE] = 1'b1;
            else if (sub[2:1] == 2'h0)
               sel[`SBSD_SP_MC_CSR] = 1'b1;
            else if (sub[2:0] == 3'h2)
               sel[`SBSD_SP_BR_CSR] = 1'b1;
            else if (sub[2:0] == 3'h3)
               sel[`SBSD_SP_IACK_SPC] = 1'b1;
            else if (sub[2:1] == 2'h2)
               sel[`SBSD_SP_SPARSE_IO] = 1'b1;
            else
               sel[`SBSD_SP_CONFIG] = 1'b1;
         end
      endcase
   end
   assign space_sel = sel;

   // claims and cache bypass
   assign mc_claim = sel[`SBSD_SP_CACHE] | sel[`SBSD_SP_NONCACHE] |
                     sel[`SBSD_SP_MC_CSR];
   // no access goes unclaimed: the bridge takes what the controller leaves
   assign br_claim = ~mc_claim; // bridge owns every other space
   assign l2_bypass = sel[`SBSD_SP_NONCACHE];

   // ********************************
   // access permission
   // ********************************
   // refusal is combinational so the processor side sees it in the request cycle
   wire mem_space;
   wire stream_ok;
   wire store_ok;
   assign mem_space = sel[`SBSD_SP_CACHE] | sel[`SBSD_SP_NONCACHE];
   // istream and dma only into main memory spaces
   assign stream_ok = mem_space | (~req_istream & ~req_dma);
   // iack and special cycles need a longword store from the processor
   assign store_ok = ~sel[`SBSD_SP_IACK_SPC] | longword_store_instruction;
   // both checks must pass before a pci request is launched
   assign access_ok = stream_ok & store_ok;

   // ********************************
   // sparse byte enables
   // ********************************
   // one encoder serves interrupt acknowledge, sparse io, config and sparse memory
   wire [3:0] sp_be_n;
   wire [2:0] sp_low_ad;
   wire sp_quad;
   wire sp_illegal;

   sbsd_sparse_be u_be (
      .len_lane(system_address[6:3]),
      .byte_en_n(sp_be_n),
      .low_ad(sp_low_ad),
      .quad_len(sp_quad),
      .illegal(sp_illegal)
   );

   // ********************************
   // pci transaction build
   // ********************************
   // next values for the registered pci request
   reg [3:0] nxt_cmd;
   reg [31:0] nxt_addr;
   reg [3:0] nxt_be_n;
   reg nxt_pref;
   reg nxt_quad;
   reg nxt_legacy;
   reg nxt_illegal;
   // spaces that turn into a pci transaction
   wire to_pci;
   assign to_pci = sel[`SBSD_SP_IACK_SPC] | sel[`SBSD_SP_SPARSE_IO] |
                   sel[`SBSD_SP_CONFIG] | sel[`SBSD_SP_SPARSE_MEM] |
                   sel[`SBSD_SP_DENSE_MEM];

   // pick command, address, lanes and limits per space
   always @* begin
      nxt_cmd = `SBSD_CMD_NONE;
      nxt_addr = 32'h0;
      nxt_be_n = `SBSD_BE_NONE;
      nxt_pref = 1'b0;
      nxt_quad = 1'b0;
      nxt_legacy = 1'b0;
      nxt_illegal = 1'b0;
      // local spaces keep the idle command and no lanes
      if (sel[`SBSD_SP_IACK_SPC]) begin
         if (req_write) begin
            nxt_cmd = `SBSD_CMD_SPECIAL; // address and lanes left don't care
         end else begin
            nxt_cmd = `SBSD_CMD_IACK;
            nxt_be_n = sp_be_n; // bits 26:7 unused
            nxt_illegal = sp_illegal;
         end
      end else if (sel[`SBSD_SP_SPARSE_IO]) begin
         nxt_cmd = req_write ? `SBSD_CMD_IO_WR : `SBSD_CMD_IO_RD;
         nxt_addr = {8'h0, system_address[28:8], sp_low_ad};
         nxt_be_n = sp_be_n;
         nxt_quad = sp_quad;
         nxt_illegal = sp_illegal;
         // flag the fixed low 256 KB window kept for legacy devices
         nxt_legacy = (system_address[28:8] >> (`SBSD_IO_RSV_TOP - 2)) == 21'h0;
      end else if (sel[`SBSD_SP_CONFIG]) begin
         // primary bus layout: device 20:16, function 15:13, register 12:7
         nxt_cmd = req_write ? `SBSD_CMD_CFG_WR : `SBSD_CMD_CFG_RD;
         nxt_addr = {8'h0, system_address[28:21], system_address[20:16],
                     system_address[15:13], system_address[12:7], 2'h0};
         nxt_be_n = sp_be_n;
         nxt_illegal = sp_illegal;
      end else if (sel[`SBSD_SP_SPARSE_MEM]) begin
         nxt_cmd = req_write ? `SBSD_CMD_MEM_WR : `SBSD_CMD_MEM_RD;
         // low bits carry mask and length, not address
         nxt_addr = {5'h0, system_address[31:8], sp_low_ad};
         nxt_be_n = sp_be_n;
         nxt_quad = sp_quad; // at most one quadword
         nxt_pref = 1'b0; // never prefetch
         nxt_illegal = sp_illegal;
      end else if (sel[`SBSD_SP_DENSE_MEM]) begin
         nxt_cmd = req_write ? `SBSD_CMD_MEM_WR : `SBSD_CMD_MEM_RD;
         // dense reads may prefetch; writes move all lanes of the word
         nxt_addr = {system_address[31:3], 3'h0};
         nxt_be_n = `SBSD_BE_ALL;
         nxt_pref = ~req_write; // reads are side-effect free
      end
   end

   // ********************************
   // output registers
   // ********************************
   // one pci request per accepted access to a pci space
   always @(posedge clock) begin
      if (srst) begin
         // idle values: no request, no command and no lanes
         pci_valid_ff <= 1'b0;
         pci_cmd_ff <= `SBSD_CMD_NONE;
         pci_addr_ff <= 32'h0;
         pci_be_n_ff <= `SBSD_BE_NONE;
         pci_prefetch_ok_ff <= 1'b0;
         pci_quad_len_ff <= 1'b0;
         pci_io_legacy_ff <= 1'b0;
         pci_illegal_ff <= 1'b0;
      end else begin
         // a refused or local access never raises the request pulse
         pci_valid_ff <= req_valid & to_pci & access_ok;
         // other fields track the address each cycle; only the pulse qualifies them
         pci_cmd_ff <= nxt_cmd;
         pci_addr_ff <= nxt_addr;
         pci_be_n_ff <= nxt_be_n;
         pci_prefetch_ok_ff <= nxt_pref;
         pci_quad_len_ff <= nxt_quad;
         pci_io_legacy_ff <= nxt_legacy;
         pci_illegal_ff <= nxt_illegal;
      end
   end

endmodule // sbsd_space_decoder
`default_nettype wire

// ### tb/sbsd_space_decoder_sva.sv
// Purpose: checker for the space decoder ports
// Assumes: one clock, srst synchronous active high
// Notes: bound to the decoder after the module
`timescale 1ns/1ps
`default_nettype none
`include "sbsd_defs.vh"
module sbsd_sva (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // request
   input wire logic [33:0] system_address,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic req_istream,
   // decode and transaction
   input wire logic [`SBSD_SP_W-1:0] space_sel,
   input wire logic mc_claim,
   input wire logic br_claim,
   input wire logic l2_bypass,
   input wire logic access_ok,
   input wire logic pci_valid_ff,
   input wire logic [3:0] pci_cmd_ff,
   input wire logic pci_prefetch_ok_ff,
   input wire logic [31:0] pci_addr_ff,
   input wire logic [3:0] pci_be_n_ff,
   input wire logic pci_quad_len_ff,
   input wire logic pci_illegal_ff
);
   // ****
   // decode, claims, refusals and accepted reads and writes per space
   // ****
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   wire [1:0] quad = system_address[33:32];
   sequence s_rd(s); req_valid && access_ok && !req_write && space_sel[s]; endsequence
   sequence s_wr(s); req_valid && access_ok && req_write && space_sel[s]; endsequence
   sequence s_acc(s); req_valid && access_ok && space_sel[s]; endsequence
   sequence s_code(s, c);
      req_valid && access_ok && !req_write && space_sel[s] && system_address[6:3] == c;
   endsequence
   property p_one; $onehot(space_sel); endproperty
   a_one: assert property (p_one) else $error("space select not one-hot");
   property p_cache; quad == 2'h0 |-> space_sel == 9'h001 && mc_claim; endproperty
   a_cache: assert property (p_cache) else $error("quadrant 0 not cacheable");
   property p_ncache; quad == 2'h1 && !system_address[31] |-> l2_bypass && space_sel[1]; endproperty
   a_ncache: assert property (p_ncache) else $error("noncacheable decode wrong");
   property p_claim; mc_claim == (|space_sel[2:0]) && br_claim == !mc_claim; endproperty
   a_claim: assert property (p_claim) else $error("claim wrong");
   property p_iack; s_rd(4) |=> pci_valid_ff && pci_cmd_ff == `SBSD_CMD_IACK; endproperty
   a_iack: assert property (p_iack) else $error("no interrupt acknowledge");
   property p_spec; s_wr(4) |=> pci_valid_ff && pci_cmd_ff == `SBSD_CMD_SPECIAL; endproperty
   a_spec: assert property (p_spec) else $error("no special cycle");
   property p_cfg; s_wr(6) |=> pci_valid_ff && pci_cmd_ff == `SBSD_CMD_CFG_WR; endproperty
   a_cfg: assert property (p_cfg) else $error("no config write");
   property p_ds; req_istream && !space_sel[0] && !space_sel[1] |-> !access_ok; endproperty
   a_ds: assert property (p_ds) else $error("istream let through");
   property p_ref; req_valid && !access_ok |=> !pci_valid_ff; endproperty
   a_ref: assert property (p_ref) else $error("refused access issued");
   property p_sparse; s_rd(7) |=> pci_valid_ff && !pci_prefetch_ok_ff; endproperty
   a_sparse: assert property (p_sparse) else $error("sparse prefetch");
   property p_dense; s_rd(8) |=> pci_prefetch_ok_ff && pci_cmd_ff == `SBSD_CMD_MEM_RD; endproperty
   a_dense: assert property (p_dense) else $error("dense read wrong");
   property p_mem; space_sel[0] || space_sel[1] |-> access_ok; endproperty
   a_mem: assert property (p_mem) else $error("memory access refused");
   property p_quad; s_code(7, 4'hf) |=> pci_quad_len_ff && pci_be_n_ff == 4'h0; endproperty
   a_quad: assert property (p_quad) else $error("sparse quadword wrong");
   property p_illeg; s_code(4, 4'h7) |=> pci_illegal_ff && pci_be_n_ff == 4'hf; endproperty
   a_illeg: assert property (p_illeg) else $error("illegal lane code not flagged");
   property p_saddr;
      s_acc(7) |=> pci_addr_ff[31:27] == 5'h0 &&
         pci_addr_ff[26:3] == $past(system_address[31:8]);
   endproperty
   a_saddr: assert property (p_saddr) else $error("sparse address wrong");
endmodule // sbsd_sva
bind sbsd_space_decoder sbsd_sva sbsd_sva_inst (.clock(clock), .srst(srst),
   .system_address(system_address), .req_valid(req_valid), .req_write(req_write),
   .req_istream(req_istream), .space_sel(space_sel), .mc_claim(mc_claim),
   .br_claim(br_claim), .l2_bypass(l2_bypass), .access_ok(access_ok),
   .pci_valid_ff(pci_valid_ff), .pci_cmd_ff(pci_cmd_ff),
   .pci_prefetch_ok_ff(pci_prefetch_ok_ff), .pci_addr_ff(pci_addr_ff),
   .pci_be_n_ff(pci_be_n_ff), .pci_quad_len_ff(pci_quad_len_ff),
   .pci_illegal_ff(pci_illegal_ff));
`default_nettype wire

// ### tb/sbsd_pci_tgt.sv
// Purpose: pci target model taking each decoder transaction
// Assumes: target claims every offered transaction at once
// Notes: captured word is cmd, byte enables, prefetch, legacy
`timescale 1ns/1ps
`default_nettype none
module sbsd_pci_tgt (
   // clock
   input wire logic clock,
   // transaction from the decoder
   input wire logic pci_valid_ff,
   input wire logic [3:0] pci_cmd_ff,
   input wire logic [3:0] pci_be_n_ff,
   input wire logic pci_prefetch_ok_ff,
   input wire logic pci_io_legacy_ff,
   // captured transaction
   output logic hit_ff,
   output logic [9:0] word_ff
);
   // latch the address phase; a zero byte enable is a live lane
   always @(posedge clock) begin
      hit_ff <= pci_valid_ff;
      word_ff <= {pci_cmd_ff, pci_be_n_ff, pci_prefetch_ok_ff, pci_io_legacy_ff};
   end
endmodule // sbsd_pci_tgt
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: self-checking bench for the space decoder
// Assumes: inputs change at the falling edge
// Notes: expected transactions queue up and are popped per hit
`timescale 1ns/1ps
`default_nettype none
`include "sbsd_defs.vh"
module tb_top;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [33:0] system_address = 34'h0;
   logic req_valid = 1'b0, req_write = 1'b0, req_istream = 1'b0, req_dma = 1'b0;
   logic longword_store_instruction = 1'b0;
   logic ok_exp;
   wire [`SBSD_SP_W-1:0] space_sel;
   wire mc_claim, br_claim, l2_bypass, access_ok, pci_valid_ff, pf, leg, hit_ff;
   wire [3:0] pci_cmd_ff, pci_be_n_ff;
   wire [9:0] word_ff;
   logic [10:0] exp_q[$];
   logic [31:0] seed = 32'h595b3d4a;
   int error_cnt = 0, checked = 0, i, k;
   sbsd_space_decoder sbsd_space_decoder_inst (.clock(clock), .srst(srst),
      .system_address(system_address), .req_valid(req_valid), .req_write(req_write),
      .req_istream(req_istream), .req_dma(req_dma),
      .longword_store_instruction(longword_store_instruction), .space_sel(space_sel),
      .mc_claim(mc_claim), .br_claim(br_claim), .l2_bypass(l2_bypass),
      .access_ok(access_ok), .pci_valid_ff(pci_valid_ff), .pci_cmd_ff(pci_cmd_ff),
      .pci_addr_ff(), .pci_be_n_ff(pci_be_n_ff), .pci_prefetch_ok_ff(pf),
      .pci_quad_len_ff(), .pci_io_legacy_ff(leg), .pci_illegal_ff());
   sbsd_pci_tgt sbsd_pci_tgt_inst (.clock(clock), .pci_valid_ff(pci_valid_ff),
      .pci_cmd_ff(pci_cmd_ff), .pci_be_n_ff(pci_be_n_ff), .pci_prefetch_ok_ff(pf),
      .pci_io_legacy_ff(leg), .hit_ff(hit_ff), .word_ff(word_ff));
   // ****
   // helpers
   // ****
   initial forever #25 clock = ~clock;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // expected space index from address bits 33:28
   function automatic int sp(input logic [5:0] t);
      if (t[5:4] != 2'h1) return t[5] ? 7 + t[4] : 0;
      if (!t[3]) return 1;
      if (t[2:1] == 2'h0) return 2;
      if (t[2:1] == 2'h1) return 3 + t[0];
      return t[1] ? 6 : 5;
   endfunction
   // sparse lane code to active-low byte enables, illegal gives none
   function automatic logic [3:0] be(input logic [3:0] c);
      return 4'(64'h0ff7ff3bf19d08ce >> (c * 4));
   endfunction
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one request per cycle; e zero means refused, top bit marks be compared
   task req(input logic [33:0] a, input logic [3:0] f, input logic [10:0] e);
      @(negedge clock);
      system_address = a;
      {req_write, req_istream, req_dma, longword_store_instruction} = f;
      req_valid = 1'b1;
      #1;
      check(access_ok, e != 11'h0);
      if (e != 11'h0) exp_q.push_back(e);
   endtask
   task wrap_up;
      $display("checked %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // compare each target hit with the oldest note
   always @(posedge clock) begin
      if (hit_ff === 1'b1) begin
         if (exp_q.size() == 0) check(1, 0);
         else begin
            check({word_ff[9:6], exp_q[0][10] ? word_ff[5:2] : exp_q[0][5:2], word_ff[1:0]},
               exp_q[0][9:0]);
            void'(exp_q.pop_front());
         end
      end
   end
   // ****
   // main sequence
   // ****
   initial begin
      repeat (5) @(negedge clock);
      check({pci_valid_ff, pci_cmd_ff, pci_be_n_ff},
         {1'b0, `SBSD_CMD_NONE, `SBSD_BE_NONE});
      srst = 1'b0;
      for (i = 0; i < 64; i++) begin
         @(negedge clock);
         seed = lfsr(seed);
         system_address = {i[5:0], seed[27:0]};
         {req_istream, req_dma, longword_store_instruction} = seed[30:28];
         #1;
         check(space_sel, 9'h001 << sp(i[5:0]));
         check(br_claim, sp(i[5:0]) > 2);
         ok_exp = (sp(i[5:0]) < 2 || seed[30:29] == 2'h0) && (sp(i[5:0]) != 4 || seed[28]);
         check(access_ok, ok_exp);
      end
      $display("space map done");
      for (i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         req({6'h1b, seed[20:0], i[3:0], 3'h0}, 4'h1, {1'b1, `SBSD_CMD_IACK, be(i), 2'h0});
      end
      $display("interrupt acknowledge done");
      req(34'h1b0000008, 4'h9, {1'b0, `SBSD_CMD_SPECIAL, 6'h0});
      req(34'h1b0000000, 4'h0, 11'h0);
      req(34'h1c0000000, 4'h1, {1'b1, `SBSD_CMD_IO_RD, 4'he, 2'h1});
      req(34'h1c0800018, 4'h8, {1'b1, `SBSD_CMD_IO_WR, 4'h0, 2'h0});
      req(34'h1c0000038, 4'h0, {1'b1, `SBSD_CMD_IO_RD, 4'hf, 2'h1});
      req(34'h1e0000000, 4'h0, {1'b0, `SBSD_CMD_CFG_RD, 6'h0});
      req(34'h1e0000000, 4'ha, 11'h0);
      req(34'h1e0000000, 4'h8, {1'b0, `SBSD_CMD_CFG_WR, 6'h0});
      req(34'h200000018, 4'h0, {1'b1, `SBSD_CMD_MEM_RD, 4'h0, 2'h0});
      seed = lfsr(seed);
      req({2'h2, seed[24:0], 4'hf, 3'h0}, 4'h0, {1'b1, `SBSD_CMD_MEM_RD, 4'h0, 2'h0});
      req(34'h200000000, 4'h8, {1'b1, `SBSD_CMD_MEM_WR, 4'he, 2'h0});
      req(34'h300000000, 4'h0, {1'b0, `SBSD_CMD_MEM_RD, 4'h0, 2'h2});
      req(34'h300000000, 4'h8, {1'b1, `SBSD_CMD_MEM_WR, 4'h0, 2'h0});
      req(34'h300000000, 4'h4, 11'h0);
      @(negedge clock);
      req_valid = 1'b0;
      for (k = 0; k < 20 && exp_q.size() != 0; k++) @(posedge clock);
      check(exp_q.size(), 0);
      $display("pci transactions done");
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
